// ==== line_rx_pkg.sv ====
// Package for the teletype line receiver: widths, timing counts, types.
// Assumes a single 40 MHz clock and an asynchronous active-low reset.
// Overview of operation
// (RULE1) Take 7.42-unit start-stop code, strip framing
// (RULE2) Five data bits per character
// (RULE3) Complete character to holding register, flag ready
// (RULE4) Computer fetches; ready drops once acquired
// (RULE5) Unfetched character overwritten by next one
// (RULE6) Overwrite raises lost-character status line
// (RULE7) Multiplexer encodes conditions into status bits
// (RULE8) Computer substitutes space, alarms, prints report
// (RULE9) Input stops: inactive status within five seconds
// (RULE10) Computer closes message after 42 seconds
// (RULE11) No mark for one character: open-line status
// (RULE12) Computer closes message after 6 seconds
// (RULE13) Oversample, qualify start at centre, mid-sample bits
package line_rx_pkg;

  localparam int unsigned CHAR_BITS       = 5;        // Data bits per char
  localparam int unsigned CLK_HZ          = 40000000; // Main clock rate
  localparam int unsigned BAUD_HZ         = 45;       // Line unit rate
  localparam int unsigned OVERSAMPLE      = 16;       // Ticks per unit
  localparam int unsigned TICK_DIV        =
    CLK_HZ / (BAUD_HZ * OVERSAMPLE);                  // Clocks per tick
  localparam int unsigned HALF_TICKS      = OVERSAMPLE / 2;
  // A character is start + five data + 1.42 stop = 7.42 units
  localparam int unsigned CHAR_TICKS      = (742 * OVERSAMPLE) / 100;
  localparam int unsigned INACTIVE_S      = 5;        // Seconds
  localparam int unsigned INACTIVE_TICKS  =
    INACTIVE_S * BAUD_HZ * OVERSAMPLE;                // Ticks, round down
  localparam int unsigned FIFO_DEPTH      = 4;        // Output buffer depth

  // Receiver states, Gray coded along the usual path
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b11,
    ST_STOP  = 2'b10
  } rx_state_type;

  // Line status lines toward the input channel mux
  typedef struct packed {
    logic lost;      // Character overwritten
    logic inactive;  // Input not continuous
    logic open_line; // No marking current
  } line_status_type;

endpackage

// ==== char_fifo.sv ====
// Small valid/ready FIFO holding assembled characters.
// Assumes one clock; full drops ready so the writer must hold its data.
module char_fifo
  import line_rx_pkg::*;
#(
  parameter int unsigned WIDTH = 5,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words
  logic [AW-1:0]    wr_ptr;       // Write index
  logic [AW-1:0]    rd_ptr;       // Read index
  logic [AW:0]      count;        // Words held
  logic             push;         // Write accepted
  logic             pop;          // Read accepted

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge mclk) disable iff (!nrst)
    count <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule

// ==== teletype_line_receiver.sv ====
// Receive side of a teletype line channel: deserialiser, holding register
// with character-ready handshake, and lost/inactive/open line status.
// Assumes line_in is synchronous to mclk, mark = 1, and that the channel
// mux pulses char_ack for one cycle when it takes the held character.
module teletype_line_receiver
  import line_rx_pkg::*;
#(
  parameter int unsigned DIV_CLOCKS = line_rx_pkg::TICK_DIV // Clocks per tick
) (
  input  wire logic                           mclk,
  input  wire logic                           nrst,
  input  wire logic                           line_in,
  input  wire logic                           char_ack,
  output logic         [line_rx_pkg::CHAR_BITS-1:0] held_char,
  output logic                                char_ready,
  output line_rx_pkg::line_status_type        status
);
  import line_rx_pkg::*;

  logic [$clog2(DIV_CLOCKS+1)-1:0] div_cnt;    // Clock divider
  logic                            tick;       // Oversample enable
  rx_state_type                    state;      // Receiver state
  logic [4:0]                      phase;      // Ticks within a unit
  logic [2:0]                      bit_idx;    // Data bit index
  logic [CHAR_BITS-1:0]            shift;      // Intermediate register
  logic                            asm_valid;  // Assembled char to FIFO
  logic                            asm_ready;  // FIFO has room
  logic [CHAR_BITS-1:0]            fifo_data;  // FIFO head
  logic                            fifo_valid; // FIFO not empty
  logic                            fifo_pop;   // Move head to holding
  logic [$clog2(INACTIVE_TICKS+1)-1:0] idle_cnt; // Ticks since last char
  logic [$clog2(CHAR_TICKS+1)-1:0] space_cnt;  // Ticks of continuous space
  logic                            char_done;  // Stop element seen
  logic                            lost_flag;  // Character overwritten
  logic                            inact_flag; // No character for 5 s
  logic                            open_flag;  // Line spacing too long

  // Status lines gathered from their own flip-flops
  assign status = '{lost:      lost_flag,
                    inactive:  inact_flag,
                    open_line: open_flag};

  // Oversample tick divider
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else if (div_cnt == $bits(div_cnt)'(DIV_CLOCKS-1)) begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  // Start qualify, mid-unit sampling, framing stripped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      phase     <= '0;
      bit_idx   <= '0;
      shift     <= '0;
      char_done <= 1'b0;
    end else begin
      char_done <= 1'b0;
      if (tick) begin
        case (state)
          // Wait for the line to read space on a tick
          ST_IDLE: begin
            phase <= '0;
            if (!line_in) begin
              state <= ST_START;
            end
          end
          // Confirm space at start centre
          ST_START: begin
            if (phase == 5'(HALF_TICKS-1)) begin
              phase <= '0;
              bit_idx <= '0;
              state <= line_in ? ST_IDLE : ST_DATA; // RULE13
            end else begin
              phase <= phase + 1'b1;
            end
          end
          // Sample each data bit at its midpoint, LSB first
          ST_DATA: begin
            if (phase == 5'(OVERSAMPLE-1)) begin
              phase <= '0;
              shift <= {line_in, shift[CHAR_BITS-1:1]}; // RULE1 RULE2
              if (bit_idx == 3'(CHAR_BITS-1)) begin
                state <= ST_STOP;
              end else begin
                bit_idx <= bit_idx + 1'b1;
              end
            end else begin
              phase <= phase + 1'b1;
            end
          end
          // Stop element: dropped, character complete
          ST_STOP: begin
            if (phase == 5'(OVERSAMPLE-1)) begin
              phase     <= '0;
              state     <= ST_IDLE;
              char_done <= line_in; // RULE1
            end else begin
              phase <= phase + 1'b1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  assign asm_valid = char_done;
  assign fifo_pop  = fifo_valid;

  // Buffer between assembly and holding register; it drains every cycle
  // into the holding register, so it never fills in practice
  char_fifo #(
    .WIDTH (CHAR_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_data   (shift),
    .in_valid  (asm_valid),
    .in_ready  (asm_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Holding register and ready handshake; a new char wins over an ack
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      held_char  <= '0;
      char_ready <= 1'b0;
    end else if (fifo_pop) begin
      held_char  <= fifo_data;  // RULE3 RULE5
      char_ready <= 1'b1;       // RULE3
    end else if (char_ack) begin
      char_ready <= 1'b0;       // RULE4
    end
  end

  // Lost flag: set on overwrite, cleared by next fetch; an ack in the
  // load cycle means the old character was taken, so nothing is lost
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lost_flag <= 1'b0;
    end else if (fifo_pop && char_ready && !char_ack) begin
      lost_flag <= 1'b1;        // RULE6
    end else if (char_ack || !asm_ready) begin
      lost_flag <= char_ack ? 1'b0 : 1'b1;
    end
  end

  // Inactive timer: restarts on each character
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt   <= '0;
      inact_flag <= 1'b0;
    end else if (char_done) begin
      idle_cnt   <= '0;
      inact_flag <= 1'b0;
    end else if (tick) begin
      if (idle_cnt == $bits(idle_cnt)'(INACTIVE_TICKS-1)) begin
        inact_flag <= 1'b1;     // RULE9
      end else begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  // Open line: space held for one whole character period
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      space_cnt <= '0;
      open_flag <= 1'b0;
    end else if (line_in) begin
      space_cnt <= '0;
      open_flag <= 1'b0;
    end else if (tick) begin
      if (space_cnt == $bits(space_cnt)'(CHAR_TICKS-1)) begin
        open_flag <= 1'b1;      // RULE11
      end else begin
        space_cnt <= space_cnt + 1'b1;
      end
    end
  end

  // Checks
  ready_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    fifo_pop |=> char_ready && held_char == $past(fifo_data))
    else $error("held char not loaded"); // RULE3
  ready_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
    char_ack && !fifo_pop |=> !char_ready)
    else $error("ready not cleared after fetch"); // RULE4
  overwrite_a: assert property (@(posedge mclk) disable iff (!nrst)
    fifo_pop && char_ready && !char_ack |=> status.lost)
    else $error("lost not flagged on overwrite"); // RULE6
  lost_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    status.lost && !char_ack |=> status.lost)
    else $error("lost dropped without fetch"); // RULE5
  done_mark_a: assert property (@(posedge mclk) disable iff (!nrst)
    char_done |-> $past(line_in))
    else $error("char done on spacing stop"); // RULE1
  start_centre_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(state == ST_DATA) |-> !$past(line_in))
    else $error("start not qualified"); // RULE13
  open_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
    line_in |=> !status.open_line)
    else $error("open line with mark"); // RULE11
  inactive_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
    char_done |=> !status.inactive)
    else $error("inactive after char"); // RULE9
  bits_cnt_a: assert property (@(posedge mclk) disable iff (!nrst)
    state == ST_DATA |-> bit_idx < 3'(CHAR_BITS))
    else $error("bit index over width"); // RULE2

  char_c: cover property (@(posedge mclk) disable iff (!nrst) char_done);
  lost_c: cover property (@(posedge mclk) disable iff (!nrst)
    $rose(status.lost));
  open_c: cover property (@(posedge mclk) disable iff (!nrst)
    $rose(status.open_line));
endmodule

// ==== mux_model.sv ====
// Far-side model: the channel mux that fetches held characters.
// Assumes the receiver holds char_ready until a one-cycle char_ack.
module mux_model #(
  parameter int INACT_WAIT = 4200, // Closing wait after inactive, cycles
  parameter int OPEN_WAIT  = 600   // Closing wait after open line, cycles
) (
  input  wire logic                            mclk,
  input  wire logic                            enable,
  input  wire logic                            char_ready,
  input  wire logic [line_rx_pkg::CHAR_BITS-1:0] held_char,
  input  wire line_rx_pkg::line_status_type    status,
  output logic                                 char_ack,
  output logic      [line_rx_pkg::CHAR_BITS-1:0] word_data,
  output line_rx_pkg::line_status_type         word_stat,
  output int                                   spaces,
  output int                                   closings
);
  timeunit 1ns;
  timeprecision 1ps;
  import line_rx_pkg::*;

  // Waits are scaled to 100 cycles per second of the real 42 s and 6 s
  localparam int CLOSE_LEN = 11;   // Characters in the closing sequence

  int   wait_cnt   = 0;            // Cycles left before closing
  logic prev_inact = 1'b0;         // Inactive line as last seen
  logic prev_open  = 1'b0;         // Open line as last seen
  logic in_msg     = 1'b0;         // Character fetched since last closing

  // Message closure: a fresh inactive report, or an open report mid-message, starts the wait, expiry sends the
  // closing sequence, counted here in characters
  always @(posedge mclk) begin
    prev_inact <= status.inactive;
    prev_open  <= status.open_line;
    if (char_ack === 1'b1) begin
      in_msg <= 1'b1;
    end
    if (status.inactive === 1'b1 && prev_inact !== 1'b1) begin
      wait_cnt <= INACT_WAIT;
    end else if (status.open_line === 1'b1 && prev_open !== 1'b1 &&
                 in_msg === 1'b1) begin
      wait_cnt <= OPEN_WAIT;
    end else if (wait_cnt == 1) begin
      wait_cnt <= 0;
      closings <= closings + CLOSE_LEN;
      in_msg   <= 1'b0;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end

  // Fetch loop: answers slowly, so char_ready must stand meanwhile
  initial begin
    char_ack = 1'b0;
    word_data = '0;
    word_stat = '0;
    spaces = 0;
    closings = 0;
    forever begin
      @(posedge mclk);
      if (enable && char_ready === 1'b1) begin
        repeat (3) @(posedge mclk);
        char_ack <= 1'b1;
        word_data <= held_char;
        word_stat <= status;
        if (status.lost === 1'b1) begin
          spaces <= spaces + 1;
        end
        @(posedge mclk);
        char_ack <= 1'b0;
        // Let the ready flag fall before looking again
        @(posedge mclk);
      end
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the teletype line receiver.
// Assumes a 40 MHz clock; line timing follows the package counts.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import line_rx_pkg::*;

  localparam int DIV = 4;                 // Scaled clocks per tick
  localparam int UNIT = OVERSAMPLE * DIV; // Clocks per line unit
  localparam int CLOSE_CHARS = 11;        // Closing sequence length

  logic                 mclk;
  logic                 nrst;
  logic                 line_in;
  logic                 mux_en;     // Lets the mux model fetch
  logic                 char_ack;
  logic                 char_ready;
  logic [CHAR_BITS-1:0] held_char;
  logic [CHAR_BITS-1:0] word_data;
  line_status_type      status;
  line_status_type      word_stat;
  int                   spaces;
  int                   closings;
  int                   errors = 0;
  int                   cmp_count = 0;
  int                   cycles = 0;

  teletype_line_receiver #(.DIV_CLOCKS(DIV)) i_dut (.mclk(mclk),
    .nrst(nrst),
    .line_in(line_in), .char_ack(char_ack), .held_char(held_char),
    .char_ready(char_ready), .status(status));

  mux_model i_mux (.mclk(mclk), .enable(mux_en), .char_ready(char_ready),
    .held_char(held_char), .status(status), .char_ack(char_ack),
    .word_data(word_data), .word_stat(word_stat), .spaces(spaces),
    .closings(closings));

  // Free-running 25 ns clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Hang guard: the whole run needs about 23 thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic close_out;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_char(input logic [CHAR_BITS-1:0] got,
                            input logic [CHAR_BITS-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_stat(input line_status_type got,
                            input line_status_type exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One start-stop character, LSB first, long idle mark after it
  task automatic send_char(input logic [CHAR_BITS-1:0] c);
    @(posedge mclk);
    line_in <= 1'b0;
    repeat (UNIT) @(posedge mclk);
    for (int i = 0; i < CHAR_BITS; i++) begin
      line_in <= c[i];
      repeat (UNIT) @(posedge mclk);
    end
    line_in <= 1'b1;
    repeat (2 * UNIT) @(posedge mclk);
  endtask

  // Bounded wait for the ready flag; the mux answers in a few cycles
  task automatic wait_ready(input logic exp);
    for (int n = 0; n < 200 && char_ready !== exp; n++) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Single character, then fetched by the mux
  task automatic test_one;
    send_char(5'h15);
    @(negedge mclk);
    check_flag(char_ready, 1'b1);
    check_char(held_char, 5'h15);
    mux_en = 1'b1;
    wait_ready(1'b0);
    check_flag(char_ready, 1'b0);
    check_char(word_data, 5'h15);
    mux_en = 1'b0;
  endtask

  // Two characters with no fetch between them
  task automatic test_lost;
    send_char(5'h0a);
    send_char(5'h13);
    @(negedge mclk);
    check_char(held_char, 5'h13);
    check_stat(status, line_status_type'(3'b100));
    mux_en = 1'b1;
    wait_ready(1'b0);
    check_stat(word_stat, line_status_type'(3'b100));
    check_flag(spaces == 1, 1'b1);
    check_stat(status, '0);
    mux_en = 1'b0;
  endtask

  // Line held spacing: open-line flag, spacing stop is dropped
  task automatic test_open;
    @(posedge mclk);
    line_in <= 1'b0;
    repeat (100 * DIV) @(posedge mclk);
    @(negedge mclk);
    check_flag(status.open_line, 1'b0);
    repeat (30 * DIV) @(posedge mclk);
    @(negedge mclk);
    check_stat(status, line_status_type'(3'b001));
    check_flag(char_ready, 1'b0);
    check_flag(closings == 0, 1'b1);
    @(posedge mclk);
    line_in <= 1'b1;
    repeat (4 * DIV) @(posedge mclk);
    @(negedge mclk);
    check_stat(status, '0);
    // Open report came mid-message: closing follows after its wait
    repeat (150 * DIV) @(posedge mclk);
    @(negedge mclk);
    check_flag(closings == CLOSE_CHARS, 1'b1);
  endtask

  // Silence after a character: inactive report, closure, then cleared
  task automatic test_inactive;
    mux_en = 1'b1;
    send_char(5'h04);
    @(negedge mclk);
    check_char(word_data, 5'h04);
    repeat ((INACTIVE_TICKS - 200) * DIV) @(posedge mclk);
    @(negedge mclk);
    check_flag(status.inactive, 1'b0);
    repeat (400 * DIV) @(posedge mclk);
    @(negedge mclk);
    check_stat(status, line_status_type'(3'b010));
    check_flag(closings == CLOSE_CHARS, 1'b1);
    repeat (1000 * DIV) @(posedge mclk);
    @(negedge mclk);
    check_flag(closings == 2 * CLOSE_CHARS, 1'b1);
    send_char(5'h1b);
    @(negedge mclk);
    check_flag(status.inactive, 1'b0);
    check_char(word_data, 5'h1b);
    mux_en = 1'b0;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    line_in = 1'b1;
    mux_en = 1'b0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    check_flag(char_ready, 1'b0);
    check_stat(status, '0);
    @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    test_one();
    test_lost();
    test_open();
    test_inactive();
    close_out();
  end
endmodule
